//--- hdl/port_direction_pin_mux_readback.sv
// Port direction, pin-shared function mux and read-back mode for ports A and B.
// Assumes an APB master on SYS_CLK and synchronous pin and peripheral inputs.
//
// Operation
// - Direction bit 1 makes pin input, 0 output; all reset to 1.
// - Read-back off: output pin reads return the data latch value.
// - Port A pin 3: io/timer0 clock, comp0 pos, analog 9, both.
// - Port A pin 2: io, opamp reference, analog 2, bus clock.
// - Port A pin 1: io, opamp output, analog 8, both.
// - Port A pin 0: code 01 bus data, others io.
// - Port A pin 7: io, comp2 pos, analog 5, both.
// - Port A pin 6: io, comp2 neg, analog 6, both.
// - Port A pin 5: 00 io, 11 second pulse output, others reserved.
// - Port A pin 4: io, comp2 output, analog 4, reference pin.
// - Port B pin 3: io/pulse trigger, comp0 neg, analog 0, both.
// - Port B pin 2: io, overvoltage sense, analog 1, both.
// - Port B pin 1: io, prescaler clock, comp1 output, comp3 output.
// - Port B pin 0: io, opamp inverting, opamp noninverting, bus data.
// - Port B pin 4: io, comp0 output, analog 3, bus clock.
// - Route bits pick bus clock and data input source pins.
// - Writing 11001010 to read-back control raises read-back mode.
// - Read-back on: port reads return live pin levels.
// - Any other read-back control value keeps the mode low.
`timescale 1ns/10ps
`include "pinmux_defines.svh"

module port_direction_pin_mux_readback (
    input  wire logic        SYS_CLK,
    input  wire logic        ARST_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic [7:0]  PORTA_PIN_IN,
    output logic      [7:0]  PORTA_PIN_OUT,
    output logic      [7:0]  PORTA_PIN_OE,
    input  wire logic [4:0]  PORTB_PIN_IN,
    output logic      [4:0]  PORTB_PIN_OUT,
    output logic      [4:0]  PORTB_PIN_OE,
    input  wire logic        OPAMP_REF_OUTPUT,
    input  wire logic        OPAMP_OUTPUT,
    input  wire logic        SECOND_PULSE_GEN_OUT,
    input  wire logic        COMPARATOR0_DIGITAL_OUT,
    input  wire logic        COMPARATOR1_DIGITAL_OUT,
    input  wire logic        COMPARATOR2_DIGITAL_OUT,
    input  wire logic        COMPARATOR3_DIGITAL_OUT,
    input  wire logic        PRESCALER_CLOCK_OUT,
    input  wire logic        BUS_CLOCK_OUT,
    input  wire logic        BUS_CLOCK_OE,
    input  wire logic        BUS_DATA_OUT,
    input  wire logic        BUS_DATA_OE,
    output logic             BUS_CLOCK_IN,
    output logic             BUS_DATA_IN,
    output logic             TIMER0_EXT_CLOCK_IN,
    output logic             PULSE_GEN_TRIGGER_IN,
    output logic      [7:0]  PORTA_ANALOG_EN,
    output logic      [4:0]  PORTB_ANALOG_EN,
    output logic             READBACK_MODE
);

    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic       rst_meta;
    logic       rst_n;

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ****************************************************************
    // Register bus decode
    // ****************************************************************
    logic [7:0] porta_data;
    logic [7:0] porta_direction;
    logic [4:0] portb_data;
    logic [4:0] portb_direction;
    logic [7:0] porta_func_sel_low;
    logic [7:0] porta_func_sel_high;
    logic [7:0] portb_func_sel_low;
    logic [1:0] portb_func_sel_high;
    logic [1:0] twowire_input_route;
    logic [7:0] readback_control;

    wire        wr_en     = PSEL && PENABLE && PWRITE;
    wire        hit_pad   = (PADDR == `OFS_PORTA_DATA);
    wire        hit_pac   = (PADDR == `OFS_PORTA_DIR);
    wire        hit_pbd   = (PADDR == `OFS_PORTB_DATA);
    wire        hit_pbc   = (PADDR == `OFS_PORTB_DIR);
    wire        hit_porta_func_sel_low  = (PADDR == `OFS_PA_SEL_LOW);
    wire        hit_porta_func_sel_high  = (PADDR == `OFS_PA_SEL_HIGH);
    wire        hit_portb_func_sel_low  = (PADDR == `OFS_PB_SEL_LOW);
    wire        hit_portb_func_sel_high  = (PADDR == `OFS_PB_SEL_HIGH);
    wire        hit_route = (PADDR == `OFS_TWOWIRE_ROUTE);
    wire        hit_rbc   = (PADDR == `OFS_READBACK_CTRL);
    wire        hit_any   = hit_pad | hit_pac | hit_pbd | hit_pbc | hit_porta_func_sel_low | hit_porta_func_sel_high
                          | hit_portb_func_sel_low | hit_portb_func_sel_high | hit_route | hit_rbc;

    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !hit_any;

    // ****************************************************************
    // Registers
    // ****************************************************************
    // Every write lands at the access edge, so routing follows from that same edge
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            porta_data          <= `DATA_RESET_A;
            portb_data          <= `DATA_RESET_B;
            porta_direction     <= `DIR_RESET_A;
            portb_direction     <= `DIR_RESET_B;
            porta_func_sel_low  <= 8'h00;
            porta_func_sel_high <= 8'h00;
            portb_func_sel_low  <= 8'h00;
            portb_func_sel_high <= 2'h0;
            twowire_input_route <= 2'h0;
            readback_control    <= 8'h00;
        end else if (wr_en) begin
            if (hit_pad)   porta_data          <= PWDATA[7:0];
            if (hit_pbd)   portb_data          <= PWDATA[4:0];
            if (hit_pac)   porta_direction     <= PWDATA[7:0];
            if (hit_pbc)   portb_direction     <= PWDATA[4:0];
            if (hit_porta_func_sel_low)  porta_func_sel_low  <= PWDATA[7:0];
            if (hit_porta_func_sel_high)  porta_func_sel_high <= PWDATA[7:0];
            if (hit_portb_func_sel_low)  portb_func_sel_low  <= PWDATA[7:0];
            if (hit_portb_func_sel_high)  portb_func_sel_high <= PWDATA[1:0];
            if (hit_route) twowire_input_route <= PWDATA[1:0];
            if (hit_rbc)   readback_control    <= PWDATA[7:0];
        end
    end

    // Exact pattern only; any other byte disables, so a stray write cannot unlock
    assign READBACK_MODE = (readback_control == `READBACK_UNLOCK);

    // ****************************************************************
    // Selector fields
    // ****************************************************************
    pinmux_pkg::sel_code_t sel_pa0, sel_pa1, sel_pa2, sel_pa3;
    pinmux_pkg::sel_code_t sel_pa4, sel_pa5, sel_pa6, sel_pa7;
    pinmux_pkg::sel_code_t sel_pb0, sel_pb1, sel_pb2, sel_pb3, sel_pb4;

    assign sel_pa0 = pinmux_pkg::sel_code_t'(porta_func_sel_low[1:0]);
    assign sel_pa1 = pinmux_pkg::sel_code_t'(porta_func_sel_low[3:2]);
    assign sel_pa2 = pinmux_pkg::sel_code_t'(porta_func_sel_low[5:4]);
    assign sel_pa3 = pinmux_pkg::sel_code_t'(porta_func_sel_low[7:6]);
    assign sel_pa4 = pinmux_pkg::sel_code_t'(porta_func_sel_high[1:0]);
    assign sel_pa5 = pinmux_pkg::sel_code_t'(porta_func_sel_high[3:2]);
    assign sel_pa6 = pinmux_pkg::sel_code_t'(porta_func_sel_high[5:4]);
    assign sel_pa7 = pinmux_pkg::sel_code_t'(porta_func_sel_high[7:6]);
    assign sel_pb0 = pinmux_pkg::sel_code_t'(portb_func_sel_low[1:0]);
    assign sel_pb1 = pinmux_pkg::sel_code_t'(portb_func_sel_low[3:2]);
    assign sel_pb2 = pinmux_pkg::sel_code_t'(portb_func_sel_low[5:4]);
    assign sel_pb3 = pinmux_pkg::sel_code_t'(portb_func_sel_low[7:6]);
    assign sel_pb4 = pinmux_pkg::sel_code_t'(portb_func_sel_high);

    // ****************************************************************
    // Pin function classes
    // ****************************************************************
    // Per pin: general digital io, peripheral digital out, bus pin, analog
    wire pa0_bus = (sel_pa0 == pinmux_pkg::SEL_CODE_1);
    wire pa0_io  = !pa0_bus;
    wire pa1_io  = (sel_pa1 == pinmux_pkg::SEL_CODE_0);
    wire pa1_drv = sel_pa1[0];
    wire pa1_an  = sel_pa1[1];
    wire pa2_io  = (sel_pa2 == pinmux_pkg::SEL_CODE_0);
    wire pa2_drv = (sel_pa2 == pinmux_pkg::SEL_CODE_1);
    wire pa2_an  = (sel_pa2 == pinmux_pkg::SEL_CODE_2);
    wire pa2_bus = (sel_pa2 == pinmux_pkg::SEL_CODE_3);
    wire pa3_io  = (sel_pa3 == pinmux_pkg::SEL_CODE_0);
    wire pa3_an  = !pa3_io;
    wire pa4_io  = (sel_pa4 == pinmux_pkg::SEL_CODE_0);
    wire pa4_drv = (sel_pa4 == pinmux_pkg::SEL_CODE_1);
    wire pa4_an  = sel_pa4[1];
    wire pa5_io  = (sel_pa5 == pinmux_pkg::SEL_CODE_0);
    wire pa5_drv = (sel_pa5 == pinmux_pkg::SEL_CODE_3);
    wire pa6_io  = (sel_pa6 == pinmux_pkg::SEL_CODE_0);
    wire pa7_io  = (sel_pa7 == pinmux_pkg::SEL_CODE_0);
    wire pb0_io  = (sel_pb0 == pinmux_pkg::SEL_CODE_0);
    wire pb0_bus = (sel_pb0 == pinmux_pkg::SEL_CODE_3);
    wire pb1_io  = (sel_pb1 == pinmux_pkg::SEL_CODE_0);
    wire pb2_io  = (sel_pb2 == pinmux_pkg::SEL_CODE_0);
    wire pb3_io  = (sel_pb3 == pinmux_pkg::SEL_CODE_0);
    wire pb4_io  = (sel_pb4 == pinmux_pkg::SEL_CODE_0);
    wire pb4_drv = (sel_pb4 == pinmux_pkg::SEL_CODE_1);
    wire pb4_an  = (sel_pb4 == pinmux_pkg::SEL_CODE_2);
    wire pb4_bus = (sel_pb4 == pinmux_pkg::SEL_CODE_3);

    wire pa1_per = OPAMP_OUTPUT;
    wire pa2_per = OPAMP_REF_OUTPUT;
    wire pb1_per = (sel_pb1 == pinmux_pkg::SEL_CODE_1) ? PRESCALER_CLOCK_OUT :
                   (sel_pb1 == pinmux_pkg::SEL_CODE_2) ? COMPARATOR1_DIGITAL_OUT :
                                                         COMPARATOR3_DIGITAL_OUT;

    wire [7:0] pa_io = {pa7_io, pa6_io, pa5_io, pa4_io, pa3_io, pa2_io, pa1_io, pa0_io};
    wire [4:0] pb_io = {pb4_io, pb3_io, pb2_io, pb1_io, pb0_io};

    // ****************************************************************
    // Pin drivers
    // ****************************************************************
    // Direction 0 drives the latch only while the pin is plain io
    wire [7:0] pa_io_oe = pa_io & ~porta_direction;
    wire [4:0] pb_io_oe = pb_io & ~portb_direction;

    assign PORTA_PIN_OE = {pa_io_oe[7:6], pa_io_oe[5] | pa5_drv, pa_io_oe[4] | pa4_drv,
                           pa_io_oe[3], pa_io_oe[2] | pa2_drv | (pa2_bus & BUS_CLOCK_OE),
                           pa_io_oe[1] | pa1_drv, pa_io_oe[0] | (pa0_bus & BUS_DATA_OE)};
    assign PORTA_PIN_OUT = {porta_data[7:6],
                            pa5_drv ? SECOND_PULSE_GEN_OUT : porta_data[5],
                            pa4_drv ? COMPARATOR2_DIGITAL_OUT : porta_data[4],
                            porta_data[3],
                            pa2_drv ? pa2_per : (pa2_bus ? BUS_CLOCK_OUT : porta_data[2]),
                            pa1_drv ? pa1_per : porta_data[1],
                            pa0_bus ? BUS_DATA_OUT : porta_data[0]};

    wire pb1_drv = !pb1_io;
    assign PORTB_PIN_OE = {pb_io_oe[4] | pb4_drv | (pb4_bus & BUS_CLOCK_OE), pb_io_oe[3:2],
                           pb_io_oe[1] | pb1_drv, pb_io_oe[0] | (pb0_bus & BUS_DATA_OE)};
    assign PORTB_PIN_OUT = {pb4_drv ? COMPARATOR0_DIGITAL_OUT : (pb4_bus ? BUS_CLOCK_OUT : portb_data[4]),
                            portb_data[3:2],
                            pb1_drv ? pb1_per : portb_data[1],
                            pb0_bus ? BUS_DATA_OUT : portb_data[0]};

    // ****************************************************************
    // Peripheral inputs and analog switches
    // ****************************************************************
    // Shared digital inputs are only valid when software also sets direction to input
    assign TIMER0_EXT_CLOCK_IN  = PORTA_PIN_IN[3];
    assign PULSE_GEN_TRIGGER_IN = PORTB_PIN_IN[3];
    assign BUS_CLOCK_IN = twowire_input_route[`BUS_CLOCK_SRC_BIT] ? PORTB_PIN_IN[4] : PORTA_PIN_IN[2];
    assign BUS_DATA_IN  = twowire_input_route[`BUS_DATA_SRC_BIT]  ? PORTB_PIN_IN[0] : PORTA_PIN_IN[0];

    assign PORTA_ANALOG_EN = {!pa7_io, !pa6_io, 1'b0, pa4_an, pa3_an, pa2_an, pa1_an, 1'b0};
    assign PORTB_ANALOG_EN = {pb4_an, !pb3_io, !pb2_io, 1'b0, !pb0_io && !pb0_bus};

    // ****************************************************************
    // Port read values
    // ****************************************************************
    // Read-back shows live pins; otherwise outputs show the latch, inputs the pin
    wire [7:0] pa_read = READBACK_MODE ? PORTA_PIN_IN
                       : ((porta_direction & PORTA_PIN_IN) | (~porta_direction & porta_data));
    wire [4:0] pb_read = READBACK_MODE ? PORTB_PIN_IN
                       : ((portb_direction & PORTB_PIN_IN) | (~portb_direction & portb_data));

    logic [31:0] next_rdata;

    always_comb begin
        next_rdata = 32'h0000_0000;
        case (1'b1)
            hit_pad:   next_rdata = {24'h000000, pa_read};
            hit_pac:   next_rdata = {24'h000000, porta_direction};
            hit_pbd:   next_rdata = {27'h0000000, pb_read};
            hit_pbc:   next_rdata = {27'h0000000, portb_direction};
            hit_porta_func_sel_low:  next_rdata = {24'h000000, porta_func_sel_low};
            hit_porta_func_sel_high:  next_rdata = {24'h000000, porta_func_sel_high};
            hit_portb_func_sel_low:  next_rdata = {24'h000000, portb_func_sel_low};
            hit_portb_func_sel_high:  next_rdata = {30'h00000000, portb_func_sel_high};
            hit_route: next_rdata = {30'h00000000, twowire_input_route};
            hit_rbc:   next_rdata = {24'h000000, readback_control};
            default:   next_rdata = 32'h0000_0000;
        endcase
    end

    // Read data is captured in the setup cycle so the access cycle shows it
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            PRDATA <= 32'h0000_0000;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            PRDATA <= next_rdata;
        end
    end

endmodule : port_direction_pin_mux_readback

//--- hdl/pinmux_defines.svh
// Register offsets, field positions and reset values for the pin mux block.
// Assumes a 32-bit APB slave with one aligned word per register.
`ifndef PINMUX_DEFINES_SVH
`define PINMUX_DEFINES_SVH

// ********************************************************************
// Register byte offsets
// ********************************************************************
`define OFS_PORTA_DATA       12'h000
`define OFS_PORTA_DIR        12'h004
`define OFS_PORTB_DATA       12'h008
`define OFS_PORTB_DIR        12'h00c
`define OFS_PA_SEL_LOW       12'h010
`define OFS_PA_SEL_HIGH      12'h014
`define OFS_PB_SEL_LOW       12'h018
`define OFS_PB_SEL_HIGH      12'h01c
`define OFS_TWOWIRE_ROUTE    12'h020
`define OFS_READBACK_CTRL    12'h024

// ********************************************************************
// Reset values and patterns
// ********************************************************************
`define DIR_RESET_A          8'hff
`define DIR_RESET_B          5'h1f
`define DATA_RESET_A         8'hff
`define DATA_RESET_B         5'h1f
`define READBACK_UNLOCK      8'hca
`define BUS_CLOCK_SRC_BIT    1
`define BUS_DATA_SRC_BIT     0

`endif

//--- hdl/pinmux_pkg.sv
// Types shared by the pin mux block.
// Assumes the defines header for numeric constants.
package pinmux_pkg;
    // Pin function codes of a two-bit selector field
    typedef enum logic [1:0] {
        SEL_CODE_0 = 2'b00,
        SEL_CODE_1 = 2'b01,
        SEL_CODE_2 = 2'b10,
        SEL_CODE_3 = 2'b11
    } sel_code_t;
endpackage : pinmux_pkg

//--- testbench/pinmux_sva.sv
// Checker for the pin mux block, watching only its top-level ports.
// Assumes it is bound to the block and that the master keeps to APB.
`timescale 1ns/10ps
`include "pinmux_defines.svh"
module pinmux_sva (
    input wire logic        SYS_CLK,
    input wire logic        ARST_N,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic [7:0]  PORTA_PIN_IN,
    input wire logic [7:0]  PORTA_PIN_OE,
    input wire logic [4:0]  PORTB_PIN_IN,
    input wire logic        BUS_CLOCK_IN,
    input wire logic        BUS_DATA_IN,
    input wire logic        TIMER0_EXT_CLOCK_IN,
    input wire logic        PULSE_GEN_TRIGGER_IN,
    input wire logic        READBACK_MODE
);
    // ********************************************************************
    // Shadow registers, so routing can be judged without the block's body
    // ********************************************************************
    logic [7:0] dir_a;
    logic [7:0] sel_a_lo;
    logic [1:0] route;
    wire        wr_edge = PSEL && PENABLE && PWRITE && PREADY;
    wire        rd_setup = PSEL && !PENABLE && !PWRITE && PADDR == `OFS_PORTA_DATA;
    wire        rb_wr = wr_edge && PADDR == `OFS_READBACK_CTRL;
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            dir_a    <= `DIR_RESET_A;
            sel_a_lo <= 8'h00;
            route    <= 2'h0;
        end else begin
            if (wr_edge && PADDR == `OFS_PORTA_DIR) dir_a <= PWDATA[7:0];
            if (wr_edge && PADDR == `OFS_PA_SEL_LOW) sel_a_lo <= PWDATA[7:0];
            if (wr_edge && PADDR == `OFS_TWOWIRE_ROUTE) route <= PWDATA[1:0];
        end
    end
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!ARST_N);
    rb_unlock_a: assert property (rb_wr && PWDATA[7:0] == `READBACK_UNLOCK |=> READBACK_MODE)
        else $error("read-back mode not raised by unlock pattern");
    rb_other_a: assert property (rb_wr && PWDATA[7:0] != `READBACK_UNLOCK |=> !READBACK_MODE)
        else $error("read-back mode raised by other pattern");
    rb_hold_a: assert property (!rb_wr |=> $stable(READBACK_MODE))
        else $error("read-back mode changed without a write");
    rb_pin_read_a: assert property (rd_setup && READBACK_MODE |=> PRDATA == {24'h0, $past(PORTA_PIN_IN)})
        else $error("read-back read not the pin levels");
    input_read_a: assert property (rd_setup && !READBACK_MODE |=>
        (PRDATA[7:0] & $past(dir_a)) == ($past(PORTA_PIN_IN) & $past(dir_a)))
        else $error("input pin read not the pin level");
    unmapped_err_a: assert property (PSEL && PENABLE && PADDR[1:0] == 2'b00 |-> PSLVERR == (PADDR > 12'h024))
        else $error("slave error wrong for address");
    bus_clk_src_a: assert property (BUS_CLOCK_IN == (route[1] ? PORTB_PIN_IN[4] : PORTA_PIN_IN[2]))
        else $error("bus clock input from wrong pin");
    bus_dat_src_a: assert property (BUS_DATA_IN == (route[0] ? PORTB_PIN_IN[0] : PORTA_PIN_IN[0]))
        else $error("bus data input from wrong pin");
    timer_in_a: assert property (TIMER0_EXT_CLOCK_IN == PORTA_PIN_IN[3])
        else $error("timer clock input not port a pin 3");
    trig_in_a: assert property (PULSE_GEN_TRIGGER_IN == PORTB_PIN_IN[3])
        else $error("trigger input not port b pin 3");
    pa0_dir_a: assert property (sel_a_lo[1:0] != 2'b01 |-> PORTA_PIN_OE[0] == !dir_a[0])
        else $error("port a pin 0 drive not set by direction");
endmodule : pinmux_sva

//--- testbench/pin_world.sv
// Model of the board around the port pins.
// Assumes no pull-ups: an undriven pin shows the level the bench picks.
`timescale 1ns/10ps
module pin_world (
    input  wire logic [7:0] a_out,
    input  wire logic [7:0] a_oe,
    input  wire logic [4:0] b_out,
    input  wire logic [4:0] b_oe,
    input  wire logic       force_pins,
    input  wire logic [7:0] a_ext,
    input  wire logic [4:0] b_ext,
    output logic      [7:0] a_in,
    output logic      [4:0] b_in
);
    // Forcing models a short stronger than the driver, so pin and latch differ
    assign a_in = force_pins ? a_ext : ((a_oe & a_out) | (~a_oe & a_ext));
    assign b_in = force_pins ? b_ext : ((b_oe & b_out) | (~b_oe & b_ext));
endmodule : pin_world

//--- testbench/tb_port_direction_pin_mux_readback.sv
// Self-checking bench for the pin mux block.
// Assumes the design, the pin model and the checker are compiled first.
`timescale 1ns/10ps
`include "pinmux_defines.svh"
module tb_port_direction_pin_mux_readback;
    logic        sys_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, force_pins = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd, w;
    logic        pready, pslverr, err, bclk_in, bdat_in, t0_in, trig_in, rb_mode;
    logic [7:0]  a_in, a_out, a_oe, a_an, a_ext = 8'h0, latch, dir, periph = 8'h0;
    logic [4:0]  b_in, b_out, b_oe, b_an, b_ext = 5'h0;
    logic        bclk_out = 1'b0, bclk_oe = 1'b0, bdat_out = 1'b0, bdat_oe = 1'b0;
    logic [1:0]  e;
    int          err_count = 0, n_checks = 0, cycles = 0;
    // Per pin, drive and analog switch for codes 00..11 with direction output
    string       func_tbl [13] = '{"odoo", "ooab", "ooak", "oaaa", "ooaa", "ozzo", "oaaa", "oaaa",
                                   "oaad", "oooo", "oaaa", "oaaa", "ooak"};
    port_direction_pin_mux_readback u_port_direction_pin_mux_readback (
        .SYS_CLK(sys_clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .PORTA_PIN_IN(a_in), .PORTA_PIN_OUT(a_out), .PORTA_PIN_OE(a_oe), .PORTB_PIN_IN(b_in),
        .PORTB_PIN_OUT(b_out), .PORTB_PIN_OE(b_oe), .OPAMP_REF_OUTPUT(periph[0]), .OPAMP_OUTPUT(periph[1]),
        .SECOND_PULSE_GEN_OUT(periph[2]), .COMPARATOR0_DIGITAL_OUT(periph[3]),
        .COMPARATOR1_DIGITAL_OUT(periph[4]), .COMPARATOR2_DIGITAL_OUT(periph[5]),
        .COMPARATOR3_DIGITAL_OUT(periph[6]), .PRESCALER_CLOCK_OUT(periph[7]), .BUS_CLOCK_OUT(bclk_out),
        .BUS_CLOCK_OE(bclk_oe), .BUS_DATA_OUT(bdat_out), .BUS_DATA_OE(bdat_oe), .BUS_CLOCK_IN(bclk_in),
        .BUS_DATA_IN(bdat_in), .TIMER0_EXT_CLOCK_IN(t0_in), .PULSE_GEN_TRIGGER_IN(trig_in),
        .PORTA_ANALOG_EN(a_an), .PORTB_ANALOG_EN(b_an), .READBACK_MODE(rb_mode));
    pin_world u_pin_world (.a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe), .force_pins(force_pins),
        .a_ext(a_ext), .b_ext(b_ext), .a_in(a_in), .b_in(b_in));
    // ********************************************************************
    // Shared tasks
    // ********************************************************************
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : print_verdict
    // Holds the request until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= data;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Returns drive enable and analog switch for one table letter
    function automatic logic [1:0] exp_pin(byte f, logic ck, logic dt);
        case (f)
            "o": return 2'b10;
            "a": return 2'b01;
            "b": return 2'b11;
            "k": return {ck, 1'b0};
            "d": return {dt, 1'b0};
            default: return 2'b00;
        endcase
    endfunction : exp_pin
    initial forever #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            print_verdict();
        end
    end
    // ********************************************************************
    // Main sequence
    // ********************************************************************
    initial begin
        void'($urandom(14738));
        repeat (10) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        for (int i = 1; i < 10; i++) begin
            if (i != 2) begin
                apb(1'b0, 12'(i * 4), 32'h0);
                check("reset value", rd, i == 1 ? 32'hff : i == 3 ? 32'h1f : 32'h0);
            end
        end
        latch = 8'($urandom);
        apb(1'b1, `OFS_PORTA_DATA, {24'($urandom), latch});
        apb(1'b1, `OFS_PORTA_DIR, 32'h0);
        force_pins <= 1'b1;
        a_ext <= ~latch;
        // Unlock pattern, upper bits ignored, then near misses
        for (int i = 0; i < 4; i++) begin
            w = i == 0 ? 32'hca : i == 1 ? 32'hffffffca : i == 2 ? 32'hcb : 32'h4a;
            apb(1'b1, `OFS_READBACK_CTRL, w);
            @(negedge sys_clk);
            check("readback mode", rb_mode, i < 2);
            check("pin out", a_out, latch);
            apb(1'b0, `OFS_PORTA_DATA, 32'h0);
            check("port a read", rd, {24'h0, i < 2 ? ~latch : latch});
        end
        for (int n = 0; n < 8; n++) begin
            dir = 8'($urandom);
            apb(1'b1, `OFS_PORTA_DIR, {24'h0, dir});
            a_ext <= 8'($urandom);
            apb(1'b0, `OFS_PORTA_DATA, 32'h0);
            check("mixed read", rd, {24'h0, (dir & a_ext) | (~dir & latch)});
        end
        for (int r = 0; r < 4; r++) begin
            apb(1'b1, `OFS_TWOWIRE_ROUTE, 32'(r));
            a_ext <= 8'($urandom);
            b_ext <= 5'($urandom);
            @(negedge sys_clk);
            check("bus clock in", bclk_in, r[1] ? b_ext[4] : a_ext[2]);
            check("bus data in", bdat_in, r[0] ? b_ext[0] : a_ext[0]);
        end
        force_pins <= 1'b0;
        apb(1'b1, `OFS_PORTA_DIR, 32'h0);
        apb(1'b1, `OFS_PORTB_DIR, 32'h0);
        for (int c = 0; c < 4; c++) begin
            for (int k = 0; k < 4; k++) apb(1'b1, 12'h010 + 12'(k * 4), {24'h0, {4{2'(c)}}});
            periph <= 8'($urandom);
            {bclk_oe, bdat_oe, bclk_out, bdat_out} <= 4'($urandom);
            @(negedge sys_clk);
            for (int p = 0; p < 13; p++) begin
                e = exp_pin(func_tbl[p][c], bclk_oe, bdat_oe);
                check("pin oe", p < 8 ? a_oe[p] : b_oe[p - 8], e[1]);
                check("analog en", p < 8 ? a_an[p] : b_an[p - 8], e[0]);
            end
            if (c == 3) check("pulse out", a_out[5], periph[2]);
            if (c == 1) check("opamp out", a_out[1], periph[1]);
            if (c == 1) check("code 1 out", {a_out[0], b_out[4], b_out[1]}, {bdat_out, periph[3], periph[7]});
            if (c == 3) check("bus out", {a_out[2], b_out[4], b_out[0]}, {bclk_out, bclk_out, bdat_out});
        end
        apb(1'b0, `OFS_PB_SEL_HIGH, 32'h0);
        check("pb sel high", rd, 32'h3);
        apb(1'b1, 12'h028, 32'hff);
        check("slave error", err, 1'b1);
        apb(1'b0, 12'h028, 32'h0);
        check("unmapped read", rd, 32'h0);
        // Function first, then direction input for the shared digital inputs
        apb(1'b1, `OFS_PA_SEL_LOW, 32'h0);
        apb(1'b1, `OFS_PB_SEL_LOW, 32'h0);
        apb(1'b1, `OFS_PORTA_DIR, 32'h08);
        apb(1'b1, `OFS_PORTB_DIR, 32'h08);
        a_ext <= 8'($urandom);
        b_ext <= 5'($urandom);
        @(negedge sys_clk);
        check("timer clock in", t0_in, a_ext[3]);
        check("trigger in", trig_in, b_ext[3]);
        print_verdict();
    end
endmodule : tb_port_direction_pin_mux_readback
bind port_direction_pin_mux_readback pinmux_sva u_pinmux_sva (
    .SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .PORTA_PIN_IN(PORTA_PIN_IN),
    .PORTA_PIN_OE(PORTA_PIN_OE), .PORTB_PIN_IN(PORTB_PIN_IN), .BUS_CLOCK_IN(BUS_CLOCK_IN),
    .BUS_DATA_IN(BUS_DATA_IN), .TIMER0_EXT_CLOCK_IN(TIMER0_EXT_CLOCK_IN),
    .PULSE_GEN_TRIGGER_IN(PULSE_GEN_TRIGGER_IN), .READBACK_MODE(READBACK_MODE));
